/* erpc_top.sv */
// Summary of operation
// - Second good pin: select 0 drives control bit 2, select 1 reads power good.
// - Third good pin: select 0 drives control bit 1, select 1 reads power good.
// - Voltage step pin: select 0 drives control bit 0, select 1 floats.
// - Second good pin pull-ups need select 0 and mode bit 3 low; pull-down select 0.
// - Third good pin pull-ups need select 0 and mode bit 2 low; pull-down select 0.
// - Step pin pull-ups need select 0 and mode bit 1 low; pull-down needs select 0.
// - Pull-up level bit 0 selects 1.8 V, bit 1 selects 3.3 V.
`timescale 1ns/1ps
`default_nettype none
module erpc_top
   import erpc_pkg::*;
#(
   parameter logic [7:0] RST_SECOND = ERPC_RST_SECOND,
   parameter logic [7:0] RST_THIRD  = ERPC_RST_THIRD,
   parameter logic [7:0] RST_VSTEP  = ERPC_RST_VSTEP
)
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   input  wire logic [7:0] control_bits,
   input  wire logic [7:0] pin_mode_bits,
   input  wire logic [2:0] pin_in,
   output logic [2:0]      pin_out,
   output logic [2:0]      pin_oe_n,
   output logic            second_power_good_signal,
   output logic            third_power_good_signal,
   output logic [2:0]      pullup_en,
   output erpc_level_type  pullup_level [3],
   output logic [5:0]      pullup_strength,
   output logic [2:0]      pulldown_en,
   output logic [5:0]      pulldown_strength
);
   erpc_cfg_if cfg_bus ();

   logic [7:0] second_cfg_q;
   logic [7:0] third_cfg_q;
   logic [7:0] vstep_cfg_q;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic       hit_second;
   logic       hit_third;
   logic       hit_vstep;
   logic [2:0] good_w;
   logic [2:0] level_w;
   logic [2:0] ctl_w;
   logic [2:0] mode_w;

   // Address decode
   assign hit_second = (reg_addr == ERPC_OFS_SECOND_GOOD);
   assign hit_third  = (reg_addr == ERPC_OFS_THIRD_GOOD);
   assign hit_vstep  = (reg_addr == ERPC_OFS_VSTEP);

   // Read mux; unmapped addresses read zero
   assign rdata_d = hit_second ? second_cfg_q :
                    hit_third  ? third_cfg_q  :
                    hit_vstep  ? vstep_cfg_q  : 8'h00;

   // Whole bytes stored, reserved bits included
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         second_cfg_q <= RST_SECOND;
         third_cfg_q  <= RST_THIRD;
         vstep_cfg_q  <= RST_VSTEP;
      end
      else if (reg_wr)
      begin
         if (hit_second)
            second_cfg_q <= reg_wdata;
         else if (hit_third)
            third_cfg_q <= reg_wdata;
         else if (hit_vstep)
            vstep_cfg_q <= reg_wdata;
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (!nrst)
         rdata_q <= 8'h00;
      else
         rdata_q <= reg_rd ? rdata_d : 8'h00;
   end
   assign reg_rdata = rdata_q;

   // Hand the bytes to the pin cells
   assign cfg_bus.cfg[0] = second_cfg_q;
   assign cfg_bus.cfg[1] = third_cfg_q;
   assign cfg_bus.cfg[2] = vstep_cfg_q;

   // Control and pin-mode bits per pin
   assign ctl_w  = {control_bits[ERPC_CTL_VSTEP], control_bits[ERPC_CTL_THIRD],
                    control_bits[ERPC_CTL_SECOND]};
   assign mode_w = {pin_mode_bits[ERPC_MODE_VSTEP], pin_mode_bits[ERPC_MODE_THIRD],
                    pin_mode_bits[ERPC_MODE_SECOND]};

   // One cell per pin; the step pin has no input function, so it floats
   generate
      for (genvar i = 0; i < ERPC_NPINS; i++)
      begin : g_pin
         erpc_pin_cell #(
            .HAS_INPUT (i != 2)
         ) u_cell (
            .clk         (clk),
            .nrst        (nrst),
            .cfg         (cfg_bus.cfg[i]),
            .ctl_bit     (ctl_w[i]),
            .mode_bit    (mode_w[i]),
            .pin_in      (pin_in[i]),
            .pin_out     (pin_out[i]),
            .pin_oe_n    (pin_oe_n[i]),
            .good        (good_w[i]),
            .pu_en       (pullup_en[i]),
            .pu_level    (level_w[i]),
            .pu_strength (pullup_strength[2*i +: 2]),
            .pd_en       (pulldown_en[i]),
            .pd_strength (pulldown_strength[2*i +: 2])
         );
         assign pullup_level[i] = erpc_level_type'(level_w[i]);
      end
   endgenerate

   // Power good only meaningful in input mode
   assign second_power_good_signal = good_w[0];
   assign third_power_good_signal  = good_w[1];
endmodule
`default_nettype wire

/* erpc_pkg.sv */
package erpc_pkg;
   // Register offsets
   localparam logic [7:0] ERPC_OFS_SECOND_GOOD = 8'h6B;
   localparam logic [7:0] ERPC_OFS_THIRD_GOOD  = 8'h6C;
   localparam logic [7:0] ERPC_OFS_VSTEP       = 8'h6D;
   // Field positions inside each pin configuration byte
   localparam int ERPC_POS_PU_LEVEL = 7;
   localparam int ERPC_POS_PU_RES   = 5;
   localparam int ERPC_POS_PD_RES   = 3;
   localparam int ERPC_POS_FSEL     = 2;
   // Control register bit driven by each pin
   localparam int ERPC_CTL_SECOND = 2;
   localparam int ERPC_CTL_THIRD  = 1;
   localparam int ERPC_CTL_VSTEP  = 0;
   // Pin-mode register bit gating each pin's pull-up
   localparam int ERPC_MODE_SECOND = 3;
   localparam int ERPC_MODE_THIRD  = 2;
   localparam int ERPC_MODE_VSTEP  = 1;
   // Values after reset (undefined by the part, so plain defaults)
   localparam logic [7:0] ERPC_RST_SECOND = 8'h00;
   localparam logic [7:0] ERPC_RST_THIRD  = 8'h00;
   localparam logic [7:0] ERPC_RST_VSTEP  = 8'h00;
   localparam int ERPC_NPINS = 3;
   // Pull-up level encoding
   typedef enum logic
   {
      ERPC_LEVEL_1V8 = 1'b0,
      ERPC_LEVEL_3V3 = 1'b1
   } erpc_level_type;
endpackage

/* erpc_cfg_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Per-pin configuration bytes handed from the register file to the pin logic
interface erpc_cfg_if;
   logic [7:0] cfg [3];
   modport regs (output cfg);
   modport pins (input cfg);
endinterface
`default_nettype wire

/* erpc_pin_cell.sv */
`timescale 1ns/1ps
`default_nettype none
// One multi-purpose pin: function select, drive and pull gating
module erpc_pin_cell
   import erpc_pkg::*;
#(
   parameter bit HAS_INPUT = 1'b1
)
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic [7:0] cfg,
   input  wire logic       ctl_bit,
   input  wire logic       mode_bit,
   input  wire logic       pin_in,
   output logic            pin_out,
   output logic            pin_oe_n,
   output logic            good,
   output logic            pu_en,
   output logic            pu_level,
   output logic [1:0]      pu_strength,
   output logic            pd_en,
   output logic [1:0]      pd_strength
);
   logic fsel;
   logic pu_on;
   logic sync1_q;
   logic sync2_q;
   logic drive;

   // Field decode and gating
   assign fsel  = cfg[ERPC_POS_FSEL];
   assign drive = ~fsel;
   assign pu_on = ~fsel & ~mode_bit; // Pull-up needs select 0 and mode bit low

   // Pin input passes two flops before use
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end
      else
      begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
      end
   end

   // Data outputs from flops; pull settings are zero while not effective
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         pin_out     <= 1'b0;
         pin_oe_n    <= 1'b1;
         good        <= 1'b0;
         pu_en       <= 1'b0;
         pu_level    <= 1'b0;
         pu_strength <= 2'h0;
         pd_en       <= 1'b0;
         pd_strength <= 2'h0;
      end
      else
      begin
         pin_out     <= ctl_bit;
         pin_oe_n    <= ~drive;
         good        <= HAS_INPUT & fsel & sync2_q;
         pu_en       <= pu_on; // Registered so enable and level move together
         pu_level    <= pu_on ? cfg[ERPC_POS_PU_LEVEL] : 1'b0;
         pu_strength <= pu_on ? cfg[ERPC_POS_PU_RES +: 2] : 2'h0;
         pd_en       <= drive;
         pd_strength <= drive ? cfg[ERPC_POS_PD_RES +: 2] : 2'h0;
      end
   end
endmodule
`default_nettype wire

/* erpc_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on pin gating and register readback
module erpc_checker
   import erpc_pkg::*;
(
   input wire logic       clk,
   input wire logic       nrst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [7:0] control_bits,
   input wire logic [7:0] pin_mode_bits,
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe_n,
   input wire logic       second_power_good_signal,
   input wire logic       third_power_good_signal,
   input wire logic [2:0] pullup_en,
   input var erpc_level_type pullup_level [3],
   input wire logic [5:0] pullup_strength,
   input wire logic [2:0] pulldown_en
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_oe_follows_sel: assert property
      (reg_wr && reg_addr == ERPC_OFS_SECOND_GOOD |-> ##2 pin_oe_n[0] == $past(reg_wdata[2], 2))
      else $error("select did not reach enable");
   a_drive_ctl_bit: assert property
      (((pin_out ^ $past({control_bits[0], control_bits[1], control_bits[2]})) & ~pin_oe_n) == 3'h0)
      else $error("driven pin differs from control bit");
   a_second_good_off: assert property (!pin_oe_n[0] |-> !second_power_good_signal)
      else $error("good flag while driving");
   a_third_good_off: assert property (!pin_oe_n[1] |-> !third_power_good_signal)
      else $error("good flag while driving");
   a_pullup_mode_gate: assert property
      ((pullup_en & $past({pin_mode_bits[1], pin_mode_bits[2], pin_mode_bits[3]})) == 3'h0)
      else $error("pull-up on with mode bit set");
   a_pulldown_gate: assert property ((pulldown_en & pin_oe_n) == 3'h0)
      else $error("pull-down on while floated");
   a_level_gate: assert property
      (pin_oe_n[2] |-> pullup_level[2] == ERPC_LEVEL_1V8 && pullup_strength[5:4] == 2'h0)
      else $error("pull-up setting while floated");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   a_unmapped_read: assert property
      (reg_rd && (reg_addr < 8'h6B || reg_addr > 8'h6D) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   c_write_read: cover property (reg_wr ##1 reg_rd);
   c_good_seen: cover property (second_power_good_signal && third_power_good_signal);
   c_step_pullup: cover property (pullup_en[2]);
endmodule
bind erpc_top erpc_checker u_chk (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .control_bits(control_bits), .pin_mode_bits(pin_mode_bits), .pin_out(pin_out),
   .pin_oe_n(pin_oe_n), .second_power_good_signal(second_power_good_signal),
   .third_power_good_signal(third_power_good_signal), .pullup_en(pullup_en),
   .pullup_level(pullup_level), .pullup_strength(pullup_strength), .pulldown_en(pulldown_en));
`default_nettype wire

/* erpc_reg_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Regulators: good outputs seen only while the pin is released
module erpc_reg_model
(
   input  wire logic [2:0] pin_out,
   input  wire logic [2:0] pin_oe_n,
   input  wire logic [1:0] pg,
   output logic [2:0]      pin_in
);
   // Floated step pin shows the inverse, so a stale value never passes
   assign pin_in[1:0] = (pin_oe_n[1:0] & pg) | (~pin_oe_n[1:0] & pin_out[1:0]);
   assign pin_in[2]   = pin_oe_n[2] ? ~pin_out[2] : pin_out[2];
endmodule
`default_nettype wire

/* test_ext_regulator_pin_config.sv */
`timescale 1ns/1ps
`default_nettype none
module test_ext_regulator_pin_config
   import erpc_pkg::*;
;
   logic           clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, good2, good3;
   logic [7:0]     addr = 8'h00, wdata = 8'h00, ctl = 8'h00, mode = 8'h00, rdata;
   logic [2:0]     pin_in, pin_out, oe_n, pu_en, pd_en;
   logic [1:0]     pg = 2'h0;
   logic [5:0]     pu_st, pd_st;
   erpc_level_type lvl [3];
   int             fail_count = 0, n_tests = 0;
   erpc_top dut (.clk(clk), .nrst(nrst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
      .reg_rd(rd), .reg_rdata(rdata), .control_bits(ctl), .pin_mode_bits(mode),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(oe_n), .second_power_good_signal(good2),
      .third_power_good_signal(good3), .pullup_en(pu_en), .pullup_level(lvl),
      .pullup_strength(pu_st), .pulldown_en(pd_en), .pulldown_strength(pd_st));
   erpc_reg_model u_reg (.pin_out(pin_out), .pin_oe_n(oe_n), .pg(pg), .pin_in(pin_in));
   initial
   begin
      forever #4 clk = ~clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Each pin: output with pulls, then mode-gated pull-up, then input or float
   task automatic pin_case(input int i);
      logic [7:0] d;
      d = (i == 1) ? 8'h70 : 8'hF0;
      @(posedge clk);
      ctl <= 8'(1 << (2 - i));
      wr_reg(ERPC_OFS_SECOND_GOOD + 8'(i), d);
      repeat (2) @(posedge clk);
      #1;
      chk({oe_n[i], pd_en[i], pu_en[i], pin_out[i], pu_st[2*i+:2], pd_st[2*i+:2]},
          8'h7E);
      chk(8'(lvl[i]), {7'h0, d[7]});
      @(posedge clk);
      mode <= 8'(1 << (3 - i));
      pg <= 2'h3;
      @(posedge clk);
      #1;
      chk({6'h0, pu_en[i], pd_en[i]}, 8'h01);
      wr_reg(ERPC_OFS_SECOND_GOOD + 8'(i), d | 8'h04);
      mode <= 8'h00;
      repeat (5) @(posedge clk);
      #1;
      chk({oe_n[i], pd_en[i], pu_en[i], pu_st[2*i+:2], pd_st[2*i+:2], (i == 0) ? good2 : good3},
          (i < 2) ? 8'h81 : 8'h81);
      chk(8'(lvl[i]), 8'h00);
   endtask
   initial
   begin
      #200000;
      fail_count++;
      tally_and_finish();
   end
   initial
   begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 4; i++)
         rd_reg(8'h6A + 8'(i), 8'h00);
      for (int i = 0; i < 3; i++)
         wr_reg(8'h6B + 8'(i), 8'h5B - 8'(i));
      wr_reg(8'h6E, 8'hFF);
      for (int i = 0; i < 3; i++)
         rd_reg(8'h6B + 8'(i), 8'h5B - 8'(i));
      rd_reg(8'h6E, 8'h00);
      for (int i = 0; i < 3; i++)
         pin_case(i);
      tally_and_finish();
   end
endmodule
`default_nettype wire
